// file: wpt_pkg.sv
// Purpose: Shared constants and types for the transmitter phase controller.
// Assumes: 125 MHz clock; packets arrive already decoded with checksum result.
// Notes:   Periods and high times are counted in clock cycles.
package wpt_pkg;
  localparam int CLK_KHZ = 125000;
  localparam int F_PING_KHZ = 175;
  localparam int F_MIN_KHZ = 115;
  localparam int F_MAX_KHZ = 205;
  localparam int PW = 12;
  localparam int TMR_W = 27;
  // Highest frequency rounds the period up so 205 kHz is never exceeded
  localparam logic [PW-1:0] PER_PING = PW'(CLK_KHZ / F_PING_KHZ);
  localparam logic [PW-1:0] HI_PING = PW'(CLK_KHZ / F_PING_KHZ / 2);
  localparam logic [PW-1:0] PER_MIN = PW'((CLK_KHZ + F_MAX_KHZ - 1) / F_MAX_KHZ);
  localparam logic [PW-1:0] PER_MAX = PW'(CLK_KHZ / F_MIN_KHZ);
  localparam logic [PW-1:0] HI_MIN = 12'h010;
  localparam int SEL_PERIOD_MS = 500;
  localparam int SEL_PERIOD_CYC = SEL_PERIOD_MS * CLK_KHZ;
  localparam int BURST_US = 100;
  localparam int BURST_CYC = BURST_US * CLK_KHZ / 1000;
  localparam int PKT_TMO_MS = 20;
  localparam int PKT_TMO_CYC = PKT_TMO_MS * CLK_KHZ;
  localparam int REMOVE_MS = 5;
  localparam int REMOVE_CYC = REMOVE_MS * CLK_KHZ;
  localparam int ADJ_US = 100;
  localparam int ADJ_CYC = ADJ_US * CLK_KHZ / 1000;
  localparam int SEQ_US = 10;
  localparam int SEQ_CYC = SEQ_US * CLK_KHZ / 1000;
  localparam int DEAD_NS = 40;
  localparam int DEAD_CYC = (DEAD_NS * CLK_KHZ + 999999) / 1000000;
  localparam logic [7:0] HDR_SS = 8'h01;
  localparam logic [7:0] HDR_EPT = 8'h02;
  localparam logic [7:0] HDR_CE = 8'h03;
  localparam logic [7:0] HDR_RP = 8'h04;
  localparam logic [7:0] HDR_CS = 8'h05;
  localparam logic [7:0] HDR_HOLD = 8'h06;
  localparam logic [7:0] HDR_PROP_LO = 8'h18;
  localparam logic [7:0] HDR_PROP_HI = 8'hF2;
  localparam logic [7:0] HDR_CFG = 8'h51;
  localparam logic [7:0] HDR_ID = 8'h71;
  localparam logic [7:0] HDR_XID = 8'h81;
  localparam int EXT_BIT = 7;
  localparam logic [2:0] OPT_MAX = 3'h7;
  localparam logic [1:0] SEQ_DONE = 2'h3;

  typedef enum logic [2:0] {
    PH_OFF, PH_BURST, PH_LISTEN, PH_PING, PH_IDCFG, PH_XFER, PH_REMOVE
  } wpt_phase_e;

  typedef enum logic [1:0] {ST_ID, ST_XID, ST_OPT} wpt_idstep_e;

  typedef struct packed {
    logic       valid;
    logic       ok;
    logic [7:0] hdr;
    logic [7:0] msg;
  } wpt_pkt_s;
endpackage

// file: wpt_inverter.sv
// Purpose: Half-bridge gate drive from a period and high-time count.
// Assumes: period_i above high_i plus two dead times.
// Notes:   Over-current cuts the upper switch until the cycle ends.
module wpt_inverter #(
  parameter int DEAD = wpt_pkg::DEAD_CYC
) (
  input  wire logic                 clk_i,     // Clock
  input  wire logic                 reset_i,   // Async reset, high
  input  wire logic                 run_i,     // Switching enable
  input  wire logic [wpt_pkg::PW-1:0] period_i, // Cycle length
  input  wire logic [wpt_pkg::PW-1:0] high_i,   // Upper on time
  input  wire logic                 ocp_i,     // Over-current flag
  output logic                      gate_hi_o, // Upper switch
  output logic                      gate_lo_o  // Lower switch
);
  typedef struct packed {
    logic [wpt_pkg::PW-1:0] cnt;
    logic                   cut;
    logic                   hi;
    logic                   lo;
  } wpt_inv_s;

  wpt_inv_s st_r, st_nxt;
  localparam logic [wpt_pkg::PW-1:0] DEAD_W = wpt_pkg::PW'(DEAD);

  generate
    if (DEAD < 1 || DEAD > 255) begin : g_chk
      $error("dead time out of range");
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    if (!run_i) begin
      st_nxt = '0;
    end else begin
      if (st_r.cnt + 12'h001 >= period_i) begin
        st_nxt.cnt = '0;
        st_nxt.cut = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + 12'h001;
        // R14 over-current cut
        if (ocp_i) begin
          st_nxt.cut = 1'b1;
        end
      end
      st_nxt.hi = (st_nxt.cnt >= DEAD_W) && (st_nxt.cnt < high_i) && !st_nxt.cut;
      // R16 shoot-through guard
      st_nxt.lo = (st_nxt.cut || (st_nxt.cnt >= high_i + DEAD_W)) && !st_nxt.hi && !st_r.hi;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gate_hi_o = st_r.hi;
  assign gate_lo_o = st_r.lo;

  a_no_shoot: assert property (@(posedge clk_i) disable iff (reset_i) // R16
    !(st_r.hi && st_r.lo) && !($past(st_r.hi) && st_r.lo))
    else $error("both switches on");
  a_ocp_cut: assert property (@(posedge clk_i) disable iff (reset_i) // R14
    (run_i && ocp_i) |=> !st_r.hi)
    else $error("upper switch on after over-current");
endmodule

// file: wpt_phase_ctrl.sv
// Purpose: Phase sequencer and operating point control of a power transmitter.
// Assumes: Packets come decoded; analog flags are synchronous to clk_i.
// Notes:   Long counts are parameters so simulation can shorten them.
// Notes on behaviour
// R1: Phases run selection, ping, identify/configure, transfer; termination returns to selection.
// R2: Selection stays low power, bursts the coil twice a second, then listens.
// R3: Ping drives the coil at 175 kHz, 50 percent duty.
// R4: No signal strength packet in the ping window stops power and restarts.
// R5: No header start bit during ping removes power after a delay.
// R6: Signal strength enters identify/configure; any other ping packet terminates power.
// R7: Receiver reports signal strength as eight bits scaled by 256.
// R8: Identify/configure needs identification 0x71 and configuration 0x51 packets.
// R9: Extended identification 0x81 is required only when the extension bit is one.
// R10: Operating point stays 175 kHz, 50 percent through identify/configure.
// R11: At most seven optional hold-off, proprietary or reserved packets are accepted.
// R12: Control error packets steer switching frequency within 115 to 205 kHz.
// R13: At the 205 kHz limit duty cycle varies as well.
// R14: Over-current turns upper switch off, lower on, for the cycle's rest.
// R15: Stop above 140 C, resume only below 110 C.
// R16: Pulse-width signal becomes complementary gate drives with shoot-through guard.
// R17: Two coil selects pick coils one and two; both high picks three.
// R18: Reset holds state at defaults; release starts from the boot state.
// R19: Enable input high means sleep; low means active.
// R20: Lockout clear and enable low sequence reference, regulators, then driver.
// R21: A packet is preamble, header, message, checksum in that order.
// R22: Missing first or following control error packet removes power.
// R23: A good packet out of sequence removes power.
// R24: Phase timeouts and removal delay are configurable cycle counts.
module wpt_phase_ctrl #(
  parameter int SEL_PERIOD = wpt_pkg::SEL_PERIOD_CYC,
  parameter int BURST      = wpt_pkg::BURST_CYC,
  parameter int PKT_TMO    = wpt_pkg::PKT_TMO_CYC,
  parameter int REMOVE_DLY = wpt_pkg::REMOVE_CYC,
  parameter int ADJ_DLY    = wpt_pkg::ADJ_CYC
) (
  input  wire logic              clk_i,           // Clock, 125 MHz
  input  wire logic              reset_i,         // Async reset, high
  input  wire logic              enable_n_i,      // Enable, low active
  input  wire logic              input_undervoltage_lockout_ok_i,       // Input above rising threshold
  input  wire logic              temp_hot_i,      // Above 140 C
  input  wire logic              temp_cool_i,     // Below 110 C
  input  wire logic              overcurrent_limit_i, // Coil current over limit
  input  wire logic [2:0]        coil_detect_i,   // Selection response per coil
  input  wire logic              start_bit_i,     // Header start bit seen
  input  wire wpt_pkg::wpt_pkt_s pkt_i,           // Decoded packet
  output wpt_pkg::wpt_phase_e    phase_o,         // Current phase
  output logic                   sleep_o,         // Low-current sleep
  output logic                   ref_en_o,        // Reference enable
  output logic                   reg_en_o,        // Regulators enable
  output logic                   drv_en_o,        // Driver control enable
  output logic                   coil_select_a_o, // Coil select A
  output logic                   coil_select_b_o, // Coil select B
  output logic                   gate_hi_o,       // Upper switch gate
  output logic                   gate_lo_o        // Lower switch gate
);
  typedef struct packed {
    wpt_pkg::wpt_phase_e  ph;
    wpt_pkg::wpt_idstep_e step;
    logic [wpt_pkg::TMR_W-1:0] tmr;
    logic [15:0]               adj;
    logic                      pend;
    logic [7:0]                err;
    logic [wpt_pkg::PW-1:0]    per;
    logic [wpt_pkg::PW-1:0]    hi;
    logic [2:0]                nopt;
    logic [2:0]                pwr;
    logic [1:0]                coil;
    logic [1:0]                seq;
    logic [15:0]               seq_cnt;
    logic                      hot;
    logic                      sleep;
    logic                      run;
    logic                      sel_a;
    logic                      sel_b;
  } wpt_ctl_s;

  wpt_ctl_s st_r, st_nxt;
  localparam logic [26:0] T_LISTEN = 27'(SEL_PERIOD - BURST);
  localparam logic [26:0] T_BURST  = 27'(BURST);
  localparam logic [26:0] T_PKT    = 27'(PKT_TMO);
  localparam logic [26:0] T_REMOVE = 27'(REMOVE_DLY);
  localparam logic [15:0] T_ADJ    = 16'(ADJ_DLY);
  localparam logic [15:0] T_SEQ    = 16'(wpt_pkg::SEQ_CYC);
  // R24 counts are parameters
  generate
    if (SEL_PERIOD <= BURST || SEL_PERIOD >= 2**27 || PKT_TMO < 1 || PKT_TMO >= 2**27 ||
        REMOVE_DLY < 1 || REMOVE_DLY >= 2**27 || ADJ_DLY < 1 || ADJ_DLY >= 2**16 ||
        BURST < 1) begin : g_chk
      $error("timing parameter out of range");
    end
  endgenerate

  // Hold-off, proprietary and reserved headers all count as optional
  function automatic logic is_optional(input logic [7:0] h);
    is_optional = !(h == wpt_pkg::HDR_SS || h == wpt_pkg::HDR_EPT ||
                    h == wpt_pkg::HDR_CE || h == wpt_pkg::HDR_RP ||
                    h == wpt_pkg::HDR_CS || h == wpt_pkg::HDR_CFG ||
                    h == wpt_pkg::HDR_ID || h == wpt_pkg::HDR_XID);
  endfunction

  function automatic logic [1:0] coil_pins(input logic [1:0] c);
    case (c)
      2'h0:    coil_pins = 2'h1;
      2'h1:    coil_pins = 2'h2;
      default: coil_pins = 2'h3;
    endcase
  endfunction

  logic good;
  logic [13:0] per_try;
  logic [13:0] hi_try;
  // R21 only checksum-good packets count
  assign good = pkt_i.valid && pkt_i.ok;
  assign per_try = {2'h0, st_r.per} + {{6{st_r.err[7]}}, st_r.err};
  assign hi_try = {2'h0, st_r.hi} + {{6{st_r.err[7]}}, st_r.err};

  always_comb begin
    st_nxt = st_r;
    st_nxt.run = 1'b0;
    if (st_r.tmr != '0) begin
      st_nxt.tmr = st_r.tmr - 27'h1;
    end
    // R15 thermal hysteresis, set wins
    if (temp_hot_i) begin
      st_nxt.hot = 1'b1;
    end else if (temp_cool_i) begin
      st_nxt.hot = 1'b0;
    end
    // R19 sleep, R20 lockout
    if (enable_n_i || !input_undervoltage_lockout_ok_i || st_r.hot) begin
      st_nxt.ph = wpt_pkg::PH_OFF;
      st_nxt.sleep = enable_n_i;
      st_nxt.seq = '0;
      st_nxt.seq_cnt = '0;
      st_nxt.pend = 1'b0;
    end else begin
      st_nxt.sleep = 1'b0;
      case (st_r.ph)
        wpt_pkg::PH_OFF: begin
          // R20 power-up sequencing
          if (st_r.seq == wpt_pkg::SEQ_DONE) begin
            st_nxt.ph = wpt_pkg::PH_BURST;
            st_nxt.tmr = T_BURST;
          end else if (st_r.seq_cnt >= T_SEQ) begin
            st_nxt.seq = st_r.seq + 2'h1;
            st_nxt.seq_cnt = '0;
          end else begin
            st_nxt.seq_cnt = st_r.seq_cnt + 16'h1;
          end
        end
        wpt_pkg::PH_BURST: begin
          // R2 short burst on the current coil
          st_nxt.run = 1'b1;
          if (st_r.tmr == '0) begin
            st_nxt.ph = wpt_pkg::PH_LISTEN;
            st_nxt.tmr = T_LISTEN;
          end
        end
        wpt_pkg::PH_LISTEN: begin
          // R2 listen, then next coil
          if (coil_detect_i[st_r.coil]) begin
            st_nxt.ph = wpt_pkg::PH_PING;
            st_nxt.tmr = T_PKT;
          end else if (st_r.tmr == '0) begin
            st_nxt.ph = wpt_pkg::PH_BURST;
            st_nxt.tmr = T_BURST;
            st_nxt.coil = (st_r.coil == 2'h2) ? 2'h0 : st_r.coil + 2'h1;
          end
        end
        wpt_pkg::PH_PING: begin
          st_nxt.run = 1'b1;
          if (good) begin
            // R6 signal strength or terminate
            if (pkt_i.hdr == wpt_pkg::HDR_SS) begin
              st_nxt.ph = wpt_pkg::PH_IDCFG;
              st_nxt.step = wpt_pkg::ST_ID;
              st_nxt.nopt = '0;
              st_nxt.tmr = T_PKT;
            end else begin
              st_nxt.ph = wpt_pkg::PH_REMOVE;
              st_nxt.tmr = T_REMOVE;
            end
          end else if (start_bit_i) begin
            st_nxt.tmr = T_PKT;
          end else if (st_r.tmr == '0) begin
            // R4 R5 window missed
            st_nxt.ph = wpt_pkg::PH_REMOVE;
            st_nxt.tmr = T_REMOVE;
          end
        end
        wpt_pkg::PH_IDCFG: begin
          st_nxt.run = 1'b1;
          if (good) begin
            st_nxt.tmr = T_PKT;
            st_nxt.ph = wpt_pkg::PH_REMOVE;
            case (st_r.step)
              wpt_pkg::ST_ID: begin
                // R8 R9 identification first
                if (pkt_i.hdr == wpt_pkg::HDR_ID) begin
                  st_nxt.ph = wpt_pkg::PH_IDCFG;
                  st_nxt.step = pkt_i.msg[wpt_pkg::EXT_BIT] ? wpt_pkg::ST_XID
                                                            : wpt_pkg::ST_OPT;
                end
              end
              wpt_pkg::ST_XID: begin
                if (pkt_i.hdr == wpt_pkg::HDR_XID) begin
                  st_nxt.ph = wpt_pkg::PH_IDCFG;
                  st_nxt.step = wpt_pkg::ST_OPT;
                end
              end
              default: begin
                // R11 up to seven optional packets
                if (pkt_i.hdr == wpt_pkg::HDR_CFG) begin
                  st_nxt.ph = wpt_pkg::PH_XFER;
                  st_nxt.pend = 1'b0;
                end else if (is_optional(pkt_i.hdr) && st_r.nopt != wpt_pkg::OPT_MAX) begin
                  st_nxt.ph = wpt_pkg::PH_IDCFG;
                  st_nxt.nopt = st_r.nopt + 3'h1;
                end
              end
            endcase
            // R23 out of sequence
            if (st_nxt.ph == wpt_pkg::PH_REMOVE) begin
              st_nxt.tmr = T_REMOVE;
            end
          end else if (st_r.tmr == '0) begin
            st_nxt.ph = wpt_pkg::PH_REMOVE;
            st_nxt.tmr = T_REMOVE;
          end
        end
        wpt_pkg::PH_XFER: begin
          st_nxt.run = 1'b1;
          if (st_r.pend) begin
            if (st_r.adj == '0) begin
              st_nxt.pend = 1'b0;
              // R12 R13 adjust frequency, duty at the limit
              if (st_r.err[7] && st_r.per == wpt_pkg::PER_MIN) begin
                st_nxt.hi = (hi_try[13] || hi_try < {2'h0, wpt_pkg::HI_MIN}) ?
                            wpt_pkg::HI_MIN : hi_try[11:0];
              end else if (!st_r.err[7] && st_r.hi < (st_r.per >> 1)) begin
                st_nxt.hi = (hi_try > {3'h0, st_r.per[11:1]}) ? (st_r.per >> 1)
                                                              : hi_try[11:0];
              end else begin
                if (per_try[13] || per_try < {2'h0, wpt_pkg::PER_MIN}) begin
                  st_nxt.per = wpt_pkg::PER_MIN;
                end else if (per_try > {2'h0, wpt_pkg::PER_MAX}) begin
                  st_nxt.per = wpt_pkg::PER_MAX;
                end else begin
                  st_nxt.per = per_try[11:0];
                end
                st_nxt.hi = st_nxt.per >> 1;
              end
            end else begin
              st_nxt.adj = st_r.adj - 16'h1;
            end
          end
          if (good) begin
            if (pkt_i.hdr == wpt_pkg::HDR_CE) begin
              // R22 each control error rearms the watchdog
              st_nxt.tmr = T_PKT;
              st_nxt.err = pkt_i.msg;
              st_nxt.pend = 1'b1;
              st_nxt.adj = T_ADJ;
            end else if (!(pkt_i.hdr == wpt_pkg::HDR_RP || pkt_i.hdr == wpt_pkg::HDR_CS ||
                           is_optional(pkt_i.hdr))) begin
              // R23 end power or stray packet
              st_nxt.ph = wpt_pkg::PH_REMOVE;
              st_nxt.tmr = T_REMOVE;
            end
          end else if (st_r.tmr == '0) begin
            // R22 control error missing
            st_nxt.ph = wpt_pkg::PH_REMOVE;
            st_nxt.tmr = T_REMOVE;
          end
        end
        wpt_pkg::PH_REMOVE: begin
          // R1 back to selection after the removal delay
          st_nxt.run = st_r.tmr != '0;
          if (st_r.tmr == '0) begin
            st_nxt.ph = wpt_pkg::PH_BURST;
            st_nxt.tmr = T_BURST;
          end
        end
        default: begin
          st_nxt.ph = wpt_pkg::PH_OFF;
        end
      endcase
    end
    // R3 R10 fixed point outside power transfer
    if (st_nxt.ph != wpt_pkg::PH_XFER) begin
      st_nxt.per = wpt_pkg::PER_PING;
      st_nxt.hi = wpt_pkg::HI_PING;
    end
    // R17 coil select pins
    {st_nxt.sel_b, st_nxt.sel_a} = coil_pins(st_nxt.coil);
    st_nxt.pwr[2] = st_nxt.ph != wpt_pkg::PH_OFF || st_nxt.seq != 2'h0 || st_nxt.seq_cnt != '0;
    st_nxt.pwr[1] = st_nxt.ph != wpt_pkg::PH_OFF || st_nxt.seq >= 2'h1;
    st_nxt.pwr[0] = st_nxt.ph != wpt_pkg::PH_OFF || st_nxt.seq >= 2'h2;
  end

  // R18 defaults under reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '{ph: wpt_pkg::PH_OFF, step: wpt_pkg::ST_ID, per: wpt_pkg::PER_PING,
                hi: wpt_pkg::HI_PING, sel_a: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  wpt_inverter u_inv (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .run_i     (st_r.run),
    .period_i  (st_r.per),
    .high_i    (st_r.hi),
    .ocp_i     (overcurrent_limit_i),
    .gate_hi_o (gate_hi_o),
    .gate_lo_o (gate_lo_o)
  );

  assign phase_o = st_r.ph;
  assign sleep_o = st_r.sleep;
  assign ref_en_o = st_r.pwr[2];
  assign reg_en_o = st_r.pwr[1];
  assign drv_en_o = st_r.pwr[0];
  assign coil_select_a_o = st_r.sel_a;
  assign coil_select_b_o = st_r.sel_b;

  sequence s_ping_ss;
    st_r.ph == wpt_pkg::PH_PING && good && pkt_i.hdr == wpt_pkg::HDR_SS &&
      !enable_n_i && input_undervoltage_lockout_ok_i && !st_r.hot;
  endsequence
  sequence s_ping_other;
    st_r.ph == wpt_pkg::PH_PING && good && pkt_i.hdr != wpt_pkg::HDR_SS &&
      !enable_n_i && input_undervoltage_lockout_ok_i && !st_r.hot;
  endsequence

  a_ss_to_idcfg: assert property (@(posedge clk_i) disable iff (reset_i) // R6
    s_ping_ss |=> st_r.ph == wpt_pkg::PH_IDCFG)
    else $error("signal strength did not enter identify phase");
  a_bad_ping: assert property (@(posedge clk_i) disable iff (reset_i) // R6
    s_ping_other |=> st_r.ph == wpt_pkg::PH_REMOVE)
    else $error("wrong ping packet kept power");
  a_fixed_point: assert property (@(posedge clk_i) disable iff (reset_i) // R10
    st_r.ph inside {wpt_pkg::PH_PING, wpt_pkg::PH_IDCFG} |->
      st_r.per == 12'h2CA && st_r.hi == 12'h165)
    else $error("operating point moved before transfer");
  a_freq_range: assert property (@(posedge clk_i) disable iff (reset_i) // R12
    st_r.per >= 12'h262 && st_r.per <= 12'h43E)
    else $error("switching period out of range");
  a_duty_limit: assert property (@(posedge clk_i) disable iff (reset_i) // R13
    st_r.hi != (st_r.per >> 1) |-> st_r.per == wpt_pkg::PER_MIN && st_r.ph == wpt_pkg::PH_XFER)
    else $error("duty changed away from upper frequency");
  a_sleep_stop: assert property (@(posedge clk_i) disable iff (reset_i) // R19
    enable_n_i |=> sleep_o && !st_r.run ##1 !gate_hi_o)
    else $error("device active while disabled");
  a_hot_hold: assert property (@(posedge clk_i) disable iff (reset_i) // R15
    (st_r.hot && !temp_cool_i) |=> st_r.hot && st_r.ph == wpt_pkg::PH_OFF)
    else $error("restart before cooling");
  a_opt_limit: assert property (@(posedge clk_i) disable iff (reset_i) // R11
    st_r.ph == wpt_pkg::PH_IDCFG && st_r.nopt == wpt_pkg::OPT_MAX && good &&
      is_optional(pkt_i.hdr) && !enable_n_i && input_undervoltage_lockout_ok_i && !st_r.hot
      |=> st_r.ph == wpt_pkg::PH_REMOVE)
    else $error("eighth optional packet accepted");
  a_coil_pins: assert property (@(posedge clk_i) disable iff (reset_i) // R17
    (st_r.sel_a || st_r.sel_b) && $stable(st_r.coil) |-> $stable({st_r.sel_a, st_r.sel_b}))
    else $error("coil select glitch");
endmodule

// file: wpt_rx_model.sv
// Purpose: Receiver at the far side of the coil link, as decoded packets.
// Assumes: Packets are presented on falling edges, one cycle each.
// Notes:   Released packet lines show the inverse of the last packet.
module wpt_rx_model (
  input  wire logic         clk_i,       // Clock
  input  wire logic         alive_i,     // Keep header start bits coming
  output logic              start_bit_o, // Header start bit
  output wpt_pkg::wpt_pkt_s pkt_o        // Decoded packet
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] tick_r;
  logic       sb_q;
  initial begin
    pkt_o = '0;
    start_bit_o = 1'b0;
    tick_r = '0;
    sb_q = 1'b0;
  end
  always @(negedge clk_i) begin
    tick_r <= tick_r + 6'h01;
    start_bit_o <= sb_q | (alive_i & (tick_r == 6'h00));
  end
  // start bit, then header and 8-bit message
  task send(input logic [7:0] h, input logic [7:0] m);
    @(posedge clk_i);
    sb_q = 1'b1;
    @(posedge clk_i);
    sb_q = 1'b0;
    @(negedge clk_i);
    pkt_o <= '{1'b1, 1'b1, h, m};
    @(negedge clk_i);
    pkt_o <= ~{1'b1, 1'b1, h, m};
  endtask
endmodule

// file: wpt_phase_ctrl_tb.sv
// Purpose: Self-checking bench for the transmitter phase controller.
// Assumes: Shortened counts: period 400, burst 20, timeout 200, removal 30.
// Notes:   Table rows walk one session; hand tests cover the faults.
module wpt_phase_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]          hdr;
    logic [7:0]          msg;
    wpt_pkg::wpt_phase_e ph;
  } wpt_row_s;
  logic                clk_i, reset_i, enable_n_i, input_undervoltage_lockout_ok_i, hot, cool, overcurrent_limit, alive, sb;
  logic                sleep_o, ref_en, reg_en, drv_en, sel_a, sel_b, g_hi, g_lo, g0;
  logic [2:0]          det;
  wpt_pkg::wpt_pkt_s   pkt;
  wpt_pkg::wpt_phase_e phase_o;
  int                  n_fail = 0, num_checks = 0, per, k;
  wpt_row_s rows [10] = '{'{8'h01, 8'hFF, wpt_pkg::PH_IDCFG}, '{8'h71, 8'h80, wpt_pkg::PH_IDCFG},
    '{8'h81, 8'h00, wpt_pkg::PH_IDCFG}, '{8'h06, 8'h00, wpt_pkg::PH_IDCFG},
    '{8'hF2, 8'h00, wpt_pkg::PH_IDCFG}, '{8'h51, 8'h00, wpt_pkg::PH_XFER},
    '{8'h03, 8'h05, wpt_pkg::PH_XFER}, '{8'h04, 8'h00, wpt_pkg::PH_XFER},
    '{8'h05, 8'h00, wpt_pkg::PH_XFER}, '{8'h02, 8'h00, wpt_pkg::PH_REMOVE}};
  wpt_phase_ctrl #(.SEL_PERIOD(400), .BURST(20), .PKT_TMO(200), .REMOVE_DLY(30), .ADJ_DLY(10))
  u_wpt_phase_ctrl (.clk_i(clk_i), .reset_i(reset_i), .enable_n_i(enable_n_i),
    .input_undervoltage_lockout_ok_i(input_undervoltage_lockout_ok_i), .temp_hot_i(hot), .temp_cool_i(cool), .overcurrent_limit_i(overcurrent_limit),
    .coil_detect_i(det), .start_bit_i(sb), .pkt_i(pkt), .phase_o(phase_o), .sleep_o(sleep_o),
    .ref_en_o(ref_en), .reg_en_o(reg_en), .drv_en_o(drv_en), .coil_select_a_o(sel_a),
    .coil_select_b_o(sel_b), .gate_hi_o(g_hi), .gate_lo_o(g_lo));
  wpt_rx_model u_wpt_rx_model (.clk_i(clk_i), .alive_i(alive), .start_bit_o(sb), .pkt_o(pkt));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wait_ph(input wpt_pkg::wpt_phase_e p, input int lim);
    for (int i = 0; i < lim && phase_o !== p; i++) @(negedge clk_i);
    chk(phase_o, p);
    if (phase_o !== p) conclude;
  endtask
  task send(input logic [7:0] h, input logic [7:0] m);
    u_wpt_rx_model.send(h, m);
    @(negedge clk_i);
  endtask
  task tend(input string s);
    $display("end of test %s, fails %0d", s, n_fail);
  endtask
  always @(negedge clk_i) if (g_hi === 1'b1 && g_lo === 1'b1) chk(2'h3, 2'h0);
  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    conclude;
  end
  initial begin
    {reset_i, enable_n_i, input_undervoltage_lockout_ok_i, hot, cool, overcurrent_limit, alive, det, g0} = 11'h508;
    repeat (10) @(negedge clk_i);
    chk({phase_o, sleep_o, ref_en, reg_en, drv_en, sel_a, sel_b, g_hi, g_lo}, 11'h008);
    reset_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk({ref_en, reg_en, drv_en}, 3'h4);
    wait_ph(wpt_pkg::PH_BURST, 4000);
    chk({ref_en, reg_en, drv_en}, 3'h7);
    wait_ph(wpt_pkg::PH_PING, 3000);
    chk({sel_a, sel_b}, 2'h3);
    tend("power-up");
    det = 3'h7;
    alive = 1'b1;
    per = 0;
    k = 0;
    for (int i = 0; i < 3000 && k < 2; i++) begin
      @(negedge clk_i);
      if (k == 1) per++;
      if (g_hi === 1'b1 && g0 === 1'b0) k++;
      g0 = g_hi;
    end
    chk(per, 714);
    for (int i = 0; i < 800 && g_hi !== 1'b1; i++) @(negedge clk_i);
    overcurrent_limit = 1'b1;
    @(negedge clk_i);
    chk(g_hi, 1'b0);
    @(negedge clk_i);
    chk(g_lo, 1'b1);
    overcurrent_limit = 1'b0;
    alive = 1'b0;
    tend("ping timing");
    foreach (rows[i]) begin
      send(rows[i].hdr, rows[i].msg);
      chk(phase_o, rows[i].ph);
    end
    wait_ph(wpt_pkg::PH_BURST, 40);
    tend("session");
    wait_ph(wpt_pkg::PH_PING, 3000);
    send(8'h03, 8'h00);
    chk(phase_o, wpt_pkg::PH_REMOVE);
    wait_ph(wpt_pkg::PH_PING, 3000);
    send(8'h01, 8'h40);
    send(8'h71, 8'h00);
    for (int i = 0; i < 8; i++) begin
      send(8'h20, 8'h00);
      chk(phase_o, (i < 7) ? wpt_pkg::PH_IDCFG : wpt_pkg::PH_REMOVE);
    end
    tend("bad packets");
    wait_ph(wpt_pkg::PH_PING, 3000);
    send(8'h01, 8'h40);
    send(8'h71, 8'h00);
    send(8'h51, 8'h00);
    chk(phase_o, wpt_pkg::PH_XFER);
    wait_ph(wpt_pkg::PH_REMOVE, 260);
    wait_ph(wpt_pkg::PH_PING, 3000);
    wait_ph(wpt_pkg::PH_REMOVE, 260);
    tend("timeouts");
    wait_ph(wpt_pkg::PH_PING, 3000);
    {hot, cool} = 2'h2;
    repeat (2) @(negedge clk_i);
    chk(phase_o, wpt_pkg::PH_OFF);
    hot = 1'b0;
    repeat (20) @(negedge clk_i);
    chk(phase_o, wpt_pkg::PH_OFF);
    cool = 1'b1;
    wait_ph(wpt_pkg::PH_BURST, 4000);
    enable_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({sleep_o, phase_o}, {1'b1, wpt_pkg::PH_OFF});
    enable_n_i = 1'b0;
    wait_ph(wpt_pkg::PH_BURST, 4000);
    tend("shutdowns");
    conclude;
  end
endmodule
